// *** core/card_act_pkg.sv ***
package card_act_pkg;
  // Voltage class bits in the class byte, class A lowest-numbered bit.
  localparam int CLASS_A_BIT = 0;
  localparam int CLASS_B_BIT = 1;
  localparam int CLASS_C_BIT = 2;
  localparam int CLASS_D_BIT = 3;
  localparam int CLASS_E_BIT = 4;
  localparam int NUM_CLASSES = 5;
  // Protocol numbers and historical byte tags.
  localparam logic [3:0] PROTO_GLOBAL = 4'hF;
  localparam logic [7:0] CATEGORY_TLV = 8'h80;
  localparam logic [7:0] TAG_CARD_DATA = 8'h31;
  localparam logic [7:0] TAG_CARD_CAPS = 8'h73;
  // Speed factor byte: high nibble clock rate index, low nibble divisor.
  localparam logic [7:0] SPEED_DEFAULT = 8'h11;
  localparam logic [7:0] SPEED_512_8 = 8'h94;
  localparam logic [7:0] SPEED_512_16 = 8'h95;
  // Global feature byte positions.
  localparam int FEAT_EXT_BIT = 7;
  localparam int FEAT_USB_BIT = 6;
  localparam int FEAT_CONTACTLESS_BIT = 5;
  localparam int FEAT_LOWZ_BIT = 4;
  localparam int FEAT_SEC_BIT = 3;
  localparam int FEAT_P2P_BIT = 2;
  localparam int FEAT_EPC_BIT = 1;
  localparam int FEAT_EXTRA_IF_BIT = 0;
  localparam logic [7:0] FEAT_NONE = 8'h00;
  // Corrupted answer limit per class.
  localparam logic [1:0] CORRUPT_LIMIT = 2'h3;
  // Answer wait, in core clocks.
  localparam logic [15:0] ATR_WAIT_CYCLES = 16'h0400;
  // Host register offsets.
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_TERM_CLASSES = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_IRQ_STATUS = 12'h00C;
  localparam logic [11:0] REG_IRQ_CLEAR = 12'h010;
  localparam logic [11:0] REG_IRQ_ENABLE = 12'h014;
  localparam logic [11:0] REG_ATR_INFO = 12'h018;
  localparam logic [11:0] REG_CORRUPT_MASK = 12'h01C;
  // Event bits.
  localparam int EV_READY = 0;
  localparam int EV_REJECT = 1;
  localparam int EV_NO_CLASS = 2;
  localparam int EV_CORRUPT = 3;
  localparam int NUM_EVENTS = 4;
  // Answer bytes: TS T0 TA1 TD1 TD2 TA3 TB3 hist[0..6] TCK.
  localparam int ATR_LEN = 15;
endpackage

// *** core/card_link_if.sv ***
`timescale 1ns/1ps
// Link between terminal and card: power class, reset, and a
// byte stream of the answer to reset. The byte strobe abstracts framing.
interface card_link_if;
  logic [4:0] power_class;
  logic card_rst_n;
  logic [7:0] atr_byte;
  logic atr_valid;
  logic atr_last;
  logic atr_corrupt;

  modport terminal (
    output power_class,
    output card_rst_n,
    input atr_byte,
    input atr_valid,
    input atr_last,
    input atr_corrupt
  );
  modport card (
    input power_class,
    input card_rst_n,
    output atr_byte,
    output atr_valid,
    output atr_last,
    output atr_corrupt
  );
endinterface

// *** core/card_atr_source.sv ***
`timescale 1ns/1ps
// Card end: after reset release at a class that powers it, sends its answer.
module card_atr_source (
  input wire logic core_clk,
  input wire logic rstn,
  card_link_if.card link,
  input wire logic [4:0] card_classes,
  input wire logic [7:0] speed_factors,
  input wire logic [7:0] features,
  input wire logic inject_corrupt,
  output logic busy
);
  logic [3:0] idx;
  logic sending;
  logic prev_rst_n;
  logic powered;
  logic [7:0] next_byte;
  logic [4:0] reach;

  // A class at or above the card's lowest-voltage class lets it start up.
  // Below that it browns out and stays silent, which drives the terminal's
  // timeout path; a card without class bits answers at any class.
  for (genvar g = 0; g < card_act_pkg::NUM_CLASSES; g++) begin : g_reach
    assign reach[g] = |(card_classes >> g);
  end
  assign powered = |(link.power_class &
    (card_classes == 5'h00 ? 5'h1F : reach));

  // Byte table of the answer; global bytes always present.
  always_comb begin
    case (idx)
      4'd0: next_byte = 8'h3B;
      4'd1: next_byte = 8'h97; // TA1 and TD1 present, seven history bytes.
      4'd2: next_byte = speed_factors;
      4'd3: next_byte = 8'h80; // TD1: TD2 follows, protocol 0.
      4'd4: next_byte = {4'h3, card_act_pkg::PROTO_GLOBAL};
      4'd5: next_byte = {3'h0, card_classes};
      4'd6: next_byte = features;
      4'd7: next_byte = card_act_pkg::CATEGORY_TLV;
      4'd8: next_byte = card_act_pkg::TAG_CARD_DATA;
      4'd9: next_byte = 8'hA0;
      4'd10: next_byte = card_act_pkg::TAG_CARD_CAPS;
      4'd11: next_byte = 8'h00;
      4'd12: next_byte = 8'h00;
      4'd13: next_byte = 8'h00;
      4'd14: next_byte = 8'h00;
      default: next_byte = 8'h00;
    endcase
  end

  // Start on reset release; one byte per clock.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sending <= 1'b0;
      idx <= 4'd0;
      prev_rst_n <= 1'b0;
    end else begin
      prev_rst_n <= link.card_rst_n;
      if (!link.card_rst_n) begin
        sending <= 1'b0;
        idx <= 4'd0;
      end else if (!prev_rst_n && powered) begin
        sending <= 1'b1;
        idx <= 4'd0;
      end else if (sending) begin
        if (idx == 4'(card_act_pkg::ATR_LEN - 1)) begin
          sending <= 1'b0;
        end else begin
          idx <= idx + 4'd1;
        end
      end
    end
  end

  // Registered link outputs.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      link.atr_byte <= 8'h00;
      link.atr_valid <= 1'b0;
      link.atr_last <= 1'b0;
      link.atr_corrupt <= 1'b0;
      busy <= 1'b0;
    end else begin
      link.atr_valid <= sending;
      link.atr_byte <= sending ? next_byte : 8'h00;
      link.atr_last <= sending && idx == 4'(card_act_pkg::ATR_LEN - 1);
      link.atr_corrupt <= sending && inject_corrupt &&
        idx == 4'(card_act_pkg::ATR_LEN - 1);
      busy <= sending;
    end
  end
endmodule

// *** core/term_activation.sv ***
`timescale 1ns/1ps
module term_activation (
  input wire logic core_clk,
  input wire logic rstn,
  card_link_if.terminal link,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  typedef enum {ST_IDLE, ST_RESET, ST_WAIT, ST_RECV, ST_READY,
    ST_STOPPED} state_t;
  state_t state;
  logic [4:0] term_classes;
  logic start_req;
  logic [2:0] cls;
  logic [1:0] corrupt_cnt;
  logic [15:0] timer;
  logic [3:0] byte_idx;
  logic [3:0] y_next;
  logic in_global;
  logic [4:0] card_classes;
  logic [7:0] speed;
  logic [7:0] features;
  logic seen_corrupt;
  logic [3:0] ev_set;
  logic [3:0] irq_status;
  logic [3:0] irq_enable;
  logic cmd_allowed;
  logic bus_wr;
  logic [2:0] hit_class;
  logic [2:0] step_class;

  // Highest class set in a mask at or below a given index, 7 when none.
  // A higher index is a lower supply voltage, so walking down the index
  // raises the voltage one supported class at a time.
  function automatic logic [2:0] top_from(input logic [4:0] m,
                                          input logic [2:0] from);
    top_from = 3'd7;
    for (int i = 0; i < card_act_pkg::NUM_CLASSES; i++) begin
      if (m[i] && 3'(i) <= from) begin
        top_from = 3'(i);
      end
    end
  endfunction

  assign bus_wr = psel && penable && pwrite;
  assign hit_class = top_from(term_classes & card_classes,
    3'(card_act_pkg::NUM_CLASSES - 1));
  assign step_class = (cls == 3'd0) ? 3'd7 :
    top_from(term_classes, cls - 3'd1);

  // Register writes from software; answers take one access cycle.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      term_classes <= 5'h00;
      irq_enable <= 4'h0;
      start_req <= 1'b0;
    end else begin
      start_req <= 1'b0;
      if (bus_wr && paddr == card_act_pkg::REG_CTRL) begin
        start_req <= pwdata[0];
      end
      if (bus_wr && paddr == card_act_pkg::REG_TERM_CLASSES) begin
        term_classes <= pwdata[4:0];
      end
      if (bus_wr && paddr == card_act_pkg::REG_IRQ_ENABLE) begin
        irq_enable <= pwdata[3:0];
      end
    end
  end

  // Activation sequencer; the class index is the class bit number.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cls <= 3'd0;
      corrupt_cnt <= 2'd0;
      timer <= 16'h0000;
      cmd_allowed <= 1'b0;
      ev_set <= 4'h0;
    end else begin
      ev_set <= 4'h0;
      case (state)
        ST_IDLE: begin
          if (start_req && term_classes != 5'h00) begin
            cls <= top_from(term_classes,
              3'(card_act_pkg::NUM_CLASSES - 1));
            corrupt_cnt <= 2'd0;
            cmd_allowed <= 1'b0;
            timer <= 16'h0000;
            state <= ST_RESET;
          end
        end
        ST_RESET: begin
          timer <= 16'h0000;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          timer <= timer + 16'h0001;
          if (link.atr_valid) begin
            state <= ST_RECV;
          end else if (timer == card_act_pkg::ATR_WAIT_CYCLES) begin
            if (step_class != 3'd7) begin
              cls <= step_class;
              corrupt_cnt <= 2'd0;
              state <= ST_RESET;
            end else begin
              ev_set[card_act_pkg::EV_REJECT] <= 1'b1;
              state <= ST_STOPPED;
            end
          end
        end
        ST_RECV: begin
          if (link.atr_valid && link.atr_last) begin
            if (seen_corrupt || link.atr_corrupt) begin
              ev_set[card_act_pkg::EV_CORRUPT] <= 1'b1;
              if (corrupt_cnt + 2'd1 < card_act_pkg::CORRUPT_LIMIT) begin
                corrupt_cnt <= corrupt_cnt + 2'd1;
                state <= ST_RESET;
              end else if (cls != 3'd0 && term_classes[cls - 3'd1]) begin
                cls <= cls - 3'd1;
                corrupt_cnt <= 2'd0;
                state <= ST_RESET;
              end else begin
                ev_set[card_act_pkg::EV_REJECT] <= 1'b1;
                state <= ST_STOPPED;
              end
            end else if (card_classes[cls] || card_classes == 5'h00) begin
              corrupt_cnt <= 2'd0;
              cmd_allowed <= 1'b1;
              ev_set[card_act_pkg::EV_READY] <= 1'b1;
              state <= ST_READY;
            end else if (hit_class != 3'd7) begin
              cls <= hit_class;
              corrupt_cnt <= 2'd0;
              state <= ST_RESET;
            end else begin
              cmd_allowed <= 1'b0;
              ev_set[card_act_pkg::EV_NO_CLASS] <= 1'b1;
              state <= ST_STOPPED;
            end
          end
        end
        ST_READY, ST_STOPPED: begin
          if (start_req) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Answer parser: walks the interface bytes generically so foreign
  // protocols, history and the check byte are accepted and skipped.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      byte_idx <= 4'd0;
      y_next <= 4'h0;
      in_global <= 1'b0;
      card_classes <= 5'h00;
      speed <= card_act_pkg::SPEED_DEFAULT;
      features <= card_act_pkg::FEAT_NONE;
      seen_corrupt <= 1'b0;
    end else if (state == ST_RESET) begin
      byte_idx <= 4'd0;
      y_next <= 4'h0;
      in_global <= 1'b0;
      card_classes <= 5'h00;
      speed <= card_act_pkg::SPEED_DEFAULT;
      features <= card_act_pkg::FEAT_NONE;
      seen_corrupt <= 1'b0;
    end else if (link.atr_valid) begin
      seen_corrupt <= seen_corrupt | link.atr_corrupt;
      if (byte_idx != 4'hF) begin
        byte_idx <= byte_idx + 4'd1;
      end
      // Byte 1 is the format byte; 2 onward follow its indicators.
      if (byte_idx == 4'd1) begin
        y_next <= link.atr_byte[7:4];
      end else if (byte_idx >= 4'd2 && y_next != 4'h0) begin
        if (y_next[0]) begin
          y_next[0] <= 1'b0;
          if (byte_idx == 4'd2) begin
            speed <= link.atr_byte;
          end else if (in_global) begin
            card_classes <= link.atr_byte[4:0];
          end
        end else if (y_next[1]) begin
          y_next[1] <= 1'b0;
          if (in_global) begin
            features <= link.atr_byte;
          end
        end else if (y_next[2]) begin
          y_next[2] <= 1'b0;
        end else begin
          y_next <= link.atr_byte[7:4];
          in_global <= byte_idx > 4'd3 &&
            link.atr_byte[3:0] == card_act_pkg::PROTO_GLOBAL;
        end
      end
    end
  end

  // Sticky interrupt status; a set in the clear cycle wins.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_status <= 4'h0;
    end else if (bus_wr && paddr == card_act_pkg::REG_IRQ_CLEAR) begin
      irq_status <= (irq_status & ~pwdata[3:0]) | ev_set;
    end else begin
      irq_status <= irq_status | ev_set;
    end
  end

  // Registered outputs: link pins, bus answer, interrupt.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      link.power_class <= 5'h00;
      link.card_rst_n <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      link.power_class <= (state == ST_IDLE || state == ST_RESET ||
        state == ST_STOPPED) ? 5'h00 : 5'(5'h01 << cls);
      link.card_rst_n <= state == ST_WAIT || state == ST_RECV ||
        state == ST_READY;
      irq <= |(irq_status & irq_enable);
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          card_act_pkg::REG_TERM_CLASSES: prdata <= {27'h0, term_classes};
          card_act_pkg::REG_STATUS:
            prdata <= {24'h0, cmd_allowed, corrupt_cnt, 2'h0, cls};
          card_act_pkg::REG_IRQ_STATUS: prdata <= {28'h0, irq_status};
          card_act_pkg::REG_IRQ_ENABLE: prdata <= {28'h0, irq_enable};
          card_act_pkg::REG_ATR_INFO:
            prdata <= {11'h0, card_classes, features, speed};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// *** verif/card_link_checker.sv ***
`timescale 1ns/1ps
// Watches the link between the two ends: answer framing and class changes.
module card_link_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [4:0] power_class,
  input wire logic card_rst_n,
  input wire logic [7:0] atr_byte,
  input wire logic atr_valid,
  input wire logic atr_last,
  input wire logic atr_corrupt
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [4:0] idx;
  // Byte position in the answer; a card reset restarts the count.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      idx <= 5'h00;
    end else if (!card_rst_n) begin
      idx <= 5'h00;
    end else if (atr_valid) begin
      idx <= idx + 5'h01;
    end
  end
  sequence s_hist_head;
    atr_byte == card_act_pkg::CATEGORY_TLV ##1
      atr_byte == card_act_pkg::TAG_CARD_DATA;
  endsequence
  sequence s_hist_caps;
    ##3 atr_byte == card_act_pkg::TAG_CARD_CAPS;
  endsequence
  property p_onehot;
    $onehot0(power_class);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("more than one class applied");
  property p_switch;
    $changed(power_class) && $past(power_class) != 5'h00
      |-> power_class == 5'h00;
  endproperty
  a_switch: assert property (p_switch)
    else $error("class changed without deactivation");
  property p_rst_pow;
    $rose(card_rst_n) |-> power_class != 5'h00;
  endproperty
  a_rst_pow: assert property (p_rst_pow)
    else $error("card reset released without supply");
  property p_global;
    atr_valid && idx == 5'h04 |-> atr_byte[3:0] == card_act_pkg::PROTO_GLOBAL;
  endproperty
  a_global: assert property (p_global)
    else $error("fifth byte does not announce global protocol");
  property p_hist;
    atr_valid && idx == 5'h07 |-> s_hist_head and s_hist_caps;
  endproperty
  a_hist: assert property (p_hist)
    else $error("historical bytes out of order");
  property p_last;
    atr_last |-> atr_valid && idx == 5'h0E;
  endproperty
  a_last: assert property (p_last)
    else $error("answer length wrong");
  property p_corrupt;
    atr_corrupt |-> atr_last;
  endproperty
  a_corrupt: assert property (p_corrupt)
    else $error("corrupt flag away from last byte");
  property p_stream;
    atr_valid && !atr_last |=> atr_valid;
  endproperty
  a_stream: assert property (p_stream)
    else $error("gap inside answer");
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rv;
  logic pready, pslverr, irq, busy;
  logic [4:0] card_classes = 5'h01;
  logic [7:0] speed_factors = 8'h11;
  logic [7:0] features = 8'h00;
  logic inject_corrupt = 1'b0;
  logic [4:0] seen[$];
  int want[$];
  int want_ev = 0;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  card_link_if link ();
  term_activation u_term_activation (.core_clk(core_clk), .rstn(rstn),
    .link(link), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  card_atr_source u_card_atr_source (.core_clk(core_clk), .rstn(rstn),
    .link(link), .card_classes(card_classes), .speed_factors(speed_factors),
    .features(features), .inject_corrupt(inject_corrupt), .busy(busy));
  card_link_checker u_card_link_checker (.core_clk(core_clk), .rstn(rstn),
    .power_class(link.power_class), .card_rst_n(link.card_rst_n),
    .atr_byte(link.atr_byte), .atr_valid(link.atr_valid),
    .atr_last(link.atr_last), .atr_corrupt(link.atr_corrupt));
  // Free running clock at 50 MHz.
  always #10 core_clk = ~core_clk;
  // Records the class at each card reset release; this is the retry trace.
  always @(posedge core_clk) begin
    if (rstn && $rose(link.card_rst_n)) seen.push_back(link.power_class);
  end
  // Cuts a hang short; four answer timeouts fit well inside the ceiling.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      results();
    end
  end
  task automatic results();
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_seq();
    chk("activations", 32'(want.size()), 32'(seen.size()));
    foreach (want[i]) if (i < seen.size()) chk("class", want[i], 32'(seen[i]));
  endtask
  // One transfer; request held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge core_clk);
      k++;
    end
    if (k == 20) n_fail++;
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Expected class trace, lowest voltage (highest index) first. Sets the
  // expected events; returns the settled index, -1 on reject, -2 when no
  // class is shared.
  function automatic int model(input int term, input int card, input int bad);
    int c;
    int top;
    want.delete();
    want_ev = 0;
    top = -1;
    for (int i = 0; i < 5; i++) if (card[i]) top = i;
    c = 4;
    while (c >= 0 && !term[c]) c--;
    while (c >= 0) begin
      want.push_back(1 << c);
      if (card != 0 && c > top) begin
        // Silent card: next higher voltage the terminal offers.
        c--;
        while (c >= 0 && !term[c]) c--;
      end else if (bad) begin
        want.push_back(1 << c);
        want.push_back(1 << c);
        want_ev = 8;
        c = (c > 0 && term[c - 1]) ? c - 1 : -1;
      end else if (card == 0 || card[c]) begin
        want_ev = 1;
        return c;
      end else if ((term & card) == 0) begin
        want_ev = 4;
        return -2;
      end else begin
        c = 4;
        while (!(term[c] && card[c])) c--;
      end
    end
    want_ev = want_ev | 2;
    return -1;
  endfunction
  logic [4:0] t_term[5] = '{5'h07, 5'h03, 5'h06, 5'h02, 5'h0F};
  logic [4:0] t_card[5] = '{5'h02, 5'h05, 5'h04, 5'h05, 5'h00};
  logic t_bad[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [7:0] spd[3] = '{card_act_pkg::SPEED_DEFAULT,
    card_act_pkg::SPEED_512_8, card_act_pkg::SPEED_512_16};
  initial begin
    int r;
    int k;
    logic [7:0] ft;
    void'($urandom(68));
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk("power", 32'h0, 32'(link.power_class));
    apb(1'b1, card_act_pkg::REG_ATR_INFO, 32'hFFFFFFFF);
    apb(1'b0, card_act_pkg::REG_ATR_INFO, 32'h0);
    chk("info", 32'(card_act_pkg::SPEED_DEFAULT), rv);
    apb(1'b0, card_act_pkg::REG_STATUS, 32'h0);
    chk("status", 32'h0, rv);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h0, rv);
    for (int i = 0; i < 5; i++) begin
      ft = (i == 0) ? card_act_pkg::FEAT_NONE : 8'($urandom);
      card_classes <= t_card[i];
      inject_corrupt <= t_bad[i];
      speed_factors <= spd[i % 3];
      features <= ft;
      seen.delete();
      apb(1'b1, card_act_pkg::REG_TERM_CLASSES, 32'(t_term[i]));
      apb(1'b1, card_act_pkg::REG_IRQ_ENABLE, 32'h0000000F);
      apb(1'b1, card_act_pkg::REG_CTRL, 32'h00000001);
      k = 0;
      rv = 32'h0;
      while (rv[2:0] === 3'b000 && k < 3000) begin
        apb(1'b0, card_act_pkg::REG_IRQ_STATUS, 32'h0);
        k++;
      end
      r = model(t_term[i], t_card[i], t_bad[i]);
      chk_seq();
      chk("events", 32'(want_ev), rv);
      chk("irq", 32'h1, 32'(irq));
      apb(1'b0, card_act_pkg::REG_STATUS, 32'h0);
      chk("allowed", 32'(r >= 0), 32'(rv[7]));
      if (r >= 0) begin
        chk("index", 32'(r), 32'(rv[2:0]));
        apb(1'b0, card_act_pkg::REG_ATR_INFO, 32'h0);
        chk("info", {11'h0, t_card[i], ft, spd[i % 3]}, rv);
      end
      apb(1'b1, card_act_pkg::REG_IRQ_ENABLE, 32'h0);
      apb(1'b0, card_act_pkg::REG_IRQ_ENABLE, 32'h0);
      chk("enable", 32'h0, rv);
      chk("masked", 32'h0, 32'(irq));
      apb(1'b1, card_act_pkg::REG_IRQ_CLEAR, 32'h0000000F);
      apb(1'b0, card_act_pkg::REG_IRQ_STATUS, 32'h0);
      chk("cleared", 32'h0, rv);
      apb(1'b1, card_act_pkg::REG_CTRL, 32'h00000001);
    end
    results();
  end
endmodule
